// >>> src/pfr_pkg.sv
// Shared constants and types of the processor flag register block.
// Assumes one clock domain; users reference everything as pfr_pkg::name.

package pfr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register locations on the plain register port
  localparam logic [7:0] PFR_FLAGS_IDX = 8'h03;
  localparam logic [7:0] PFR_FLAGS_ALT_IDX = 8'h83;
  localparam logic [7:0] PFR_OPTION_IDX = 8'h81;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside processor_flags
  localparam int PFR_CARRY_BIT = 0;
  localparam int PFR_NIBBLE_BIT = 1;
  localparam int PFR_ZERO_BIT = 2;
  localparam int PFR_PDOWN_BIT = 3;
  localparam int PFR_WDEXP_BIT = 4;
  localparam int PFR_BANK_BIT = 5;
  localparam int PFR_UPPER_BIT = 6;
  localparam int PFR_INDIRECT_BIT = 7;

  // Prescaler assignment field of the option register
  localparam int PFR_PRESCALER_ASSIGN_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] PFR_FLAGS_RST = 8'h18;
  localparam logic [7:0] PFR_OPTION_RST = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Operations issued by the core
  typedef enum logic [3:0] {
    PFR_OP_NONE,
    PFR_OP_ADD,
    PFR_OP_SUB,
    PFR_OP_AND,
    PFR_OP_IOR,
    PFR_OP_XOR,
    PFR_OP_INC,
    PFR_OP_ROT_LEFT,
    PFR_OP_ROT_RIGHT,
    PFR_OP_CLEAR_FILE,
    PFR_OP_MOVE_W,
    PFR_OP_BIT_CLEAR,
    PFR_OP_BIT_SET,
    PFR_OP_NIBBLE_SWAP
  } pfr_op_t;

  typedef struct packed {
    logic valid;
    pfr_op_t op;
    logic dest_flags;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [2:0] bitsel;
  } pfr_instr_t;

  typedef struct packed {
    logic [7:0] result;
    logic zero;
    logic nibble;
    logic carry;
    logic zero_en;
    logic nibble_en;
    logic carry_en;
  } pfr_alu_t;

  typedef struct packed {
    logic expiry;
    logic wd_clear;
    logic sleep_entry;
  } pfr_event_t;

endpackage

// >>> src/pfr_alu.sv
// Combinational ALU producing a result and the three arithmetic flags.
// Assumes operands are stable for the cycle in which the core issues them.

`timescale 1ns/1ps
`default_nettype none

module pfr_alu (
  input wire pfr_pkg::pfr_op_t op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic [2:0] bitsel,
  input wire logic carry_in,
  output var pfr_pkg::pfr_alu_t alu_o
);

  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] mask;

  assign mask = 8'h01 << bitsel;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    alu_o = '0;
    sum = '0;
    low = '0;
    case (op)
      pfr_pkg::PFR_OP_ADD: begin
        sum = {1'b0, opa} + {1'b0, opb};
        low = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
      end
      pfr_pkg::PFR_OP_SUB: begin
        // Two's complement add, so carry is an inverted borrow
        sum = {1'b0, opa} + {1'b0, ~opb} + 9'h001; // RQ8
        low = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + 5'h01; // RQ7
      end
      pfr_pkg::PFR_OP_INC: sum = {1'b0, opa} + 9'h001;
      default: sum = '0;
    endcase
    case (op)
      pfr_pkg::PFR_OP_ADD, pfr_pkg::PFR_OP_SUB: begin
        alu_o.result = sum[7:0];
        alu_o.carry = sum[8]; // RQ13
        alu_o.nibble = low[4]; // RQ13
        alu_o.carry_en = 1'b1;
        alu_o.nibble_en = 1'b1;
        alu_o.zero_en = 1'b1;
      end
      pfr_pkg::PFR_OP_AND: begin
        alu_o.result = opa & opb;
        alu_o.zero_en = 1'b1;
      end
      pfr_pkg::PFR_OP_IOR: begin
        alu_o.result = opa | opb;
        alu_o.zero_en = 1'b1;
      end
      pfr_pkg::PFR_OP_XOR: begin
        alu_o.result = opa ^ opb;
        alu_o.zero_en = 1'b1;
      end
      pfr_pkg::PFR_OP_INC: begin
        alu_o.result = sum[7:0];
        alu_o.zero_en = 1'b1;
      end
      pfr_pkg::PFR_OP_ROT_LEFT: begin
        alu_o.result = {opa[6:0], carry_in};
        alu_o.carry = opa[7]; // RQ9
        alu_o.carry_en = 1'b1;
      end
      pfr_pkg::PFR_OP_ROT_RIGHT: begin
        alu_o.result = {carry_in, opa[7:1]};
        alu_o.carry = opa[0]; // RQ9
        alu_o.carry_en = 1'b1;
      end
      pfr_pkg::PFR_OP_CLEAR_FILE: begin
        alu_o.result = 8'h00;
        alu_o.zero_en = 1'b1;
      end
      pfr_pkg::PFR_OP_MOVE_W: alu_o.result = opb;
      pfr_pkg::PFR_OP_BIT_CLEAR: alu_o.result = opa & ~mask;
      pfr_pkg::PFR_OP_BIT_SET: alu_o.result = opa | mask;
      pfr_pkg::PFR_OP_NIBBLE_SWAP: alu_o.result = {opa[3:0], opa[7:4]};
      default: alu_o.result = opa;
    endcase
    alu_o.zero = (alu_o.result == 8'h00); // RQ13
  end

endmodule

`default_nettype wire

// >>> src/pfr_flags.sv
// Processor flag register, option register and direct bank address.
// Assumes a core issuing one operation per cycle and one-cycle event pulses.
//
// Function
// RQ1: Flag-affecting operation aimed here keeps computed zero, nibble and carry.
// RQ2: Watchdog-expiry and power-down flags ignore all writes.
// RQ3: Clear-file aimed here clears top three bits, sets zero, keeps rest.
// RQ4: Software should alter flags only with bit, swap or move-W operations.
// RQ5: Software keeps the indirect and upper bank bits at zero.
// RQ6: Bank select bit forms bit 7 of the direct data address.
// RQ7: Subtraction gives nibble flag as inverted digit borrow.
// RQ8: Subtraction adds two's complement; carry is inverted borrow.
// RQ9: Rotates load carry with bit shifted out of source.
// RQ10: Option register is fully readable and writable.
// RQ11: Software sets prescaler assign bit for undivided timer zero.
// RQ12: Expiry and power-down flags follow power-up, watchdog clear, sleep, timeout.
// RQ13: Zero on zero result, nibble from bit 3 carry, carry from bit 7.

`timescale 1ns/1ps
`default_nettype none

module pfr_flags (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata_r,
  input wire pfr_pkg::pfr_instr_t ins,
  input wire pfr_pkg::pfr_event_t ev,
  input wire logic [6:0] dir_addr,
  output logic [7:0] mem_addr_r,
  output logic [7:0] result_r,
  output logic result_valid_r,
  output logic [7:0] flags_r,
  output logic [7:0] option_r
);

  localparam int CY = pfr_pkg::PFR_CARRY_BIT;
  localparam int NB = pfr_pkg::PFR_NIBBLE_BIT;
  localparam int ZR = pfr_pkg::PFR_ZERO_BIT;
  localparam int PD = pfr_pkg::PFR_PDOWN_BIT;
  localparam int WD = pfr_pkg::PFR_WDEXP_BIT;
  localparam int BK = pfr_pkg::PFR_BANK_BIT;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] idx);
    addr_hit = (a == idx);
  endfunction

  logic flags_hit;
  logic opt_hit;
  logic [7:0] opa_eff;
  logic [7:0] flags_nxt;
  pfr_pkg::pfr_alu_t alu_o;

  assign flags_hit = addr_hit(bus_addr, pfr_pkg::PFR_FLAGS_IDX) |
                     addr_hit(bus_addr, pfr_pkg::PFR_FLAGS_ALT_IDX);
  assign opt_hit = addr_hit(bus_addr, pfr_pkg::PFR_OPTION_IDX);

  // Operations aimed at the flags work on the live flag value
  assign opa_eff = ins.dest_flags ? flags_r : ins.opa;

  ////////////////////////////////////////////////////////////////////////////
  pfr_alu u_alu (
    .op(ins.op),
    .opa(opa_eff),
    .opb(ins.opb),
    .bitsel(ins.bitsel),
    .carry_in(flags_r[CY]),
    .alu_o(alu_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next flag value; the core's operation outranks a port write
  always_comb begin
    flags_nxt = flags_r;
    if (ins.valid && ins.dest_flags) begin
      flags_nxt = alu_o.result;
      // Computed flags beat the written result bits
      if (alu_o.zero_en) begin
        flags_nxt[ZR] = alu_o.zero; // RQ1
      end
      if (alu_o.nibble_en) begin
        flags_nxt[NB] = alu_o.nibble; // RQ1
      end
      if (alu_o.carry_en) begin
        flags_nxt[CY] = alu_o.carry; // RQ1
      end
      if (ins.op == pfr_pkg::PFR_OP_CLEAR_FILE) begin
        flags_nxt[NB] = flags_r[NB]; // RQ3
        flags_nxt[CY] = flags_r[CY]; // RQ3
      end
    end else if (ins.valid) begin
      if (alu_o.zero_en) begin
        flags_nxt[ZR] = alu_o.zero; // RQ13
      end
      if (alu_o.nibble_en) begin
        flags_nxt[NB] = alu_o.nibble; // RQ7
      end
      if (alu_o.carry_en) begin
        flags_nxt[CY] = alu_o.carry; // RQ8
      end
    end else if (bus_wr && flags_hit) begin
      flags_nxt = bus_wdata;
    end
    // Only reset, watchdog and sleep logic move these two
    flags_nxt[WD] = flags_r[WD]; // RQ2
    flags_nxt[PD] = flags_r[PD]; // RQ2
    if (ev.wd_clear) begin
      flags_nxt[WD] = 1'b1; // RQ12
      flags_nxt[PD] = 1'b1; // RQ12
    end
    if (ev.sleep_entry) begin
      flags_nxt[WD] = 1'b1; // RQ12
      flags_nxt[PD] = 1'b0; // RQ12
    end
    // Timeout wins so a late expiry is never masked
    if (ev.expiry) begin
      flags_nxt[WD] = 1'b0; // RQ12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= pfr_pkg::PFR_FLAGS_RST; // RQ12
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      option_r <= pfr_pkg::PFR_OPTION_RST;
    end else if (bus_wr && opt_hit) begin
      option_r <= bus_wdata; // RQ10
    end
  end

  // Address is built from the bank in force when issued
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_r <= 8'h00;
    end else begin
      mem_addr_r <= {flags_r[BK], dir_addr}; // RQ6
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= 8'h00;
      result_valid_r <= 1'b0;
    end else begin
      result_r <= ins.valid ? alu_o.result : result_r;
      result_valid_r <= ins.valid;
    end
  end

  // Read data lives for one cycle only; unmapped reads give zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_r <= 8'h00;
    end else if (bus_rd && flags_hit) begin
      bus_rdata_r <= flags_r;
    end else if (bus_rd && opt_hit) begin
      bus_rdata_r <= option_r; // RQ10
    end else begin
      bus_rdata_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_plain_flag_wr;
    bus_wr && flags_hit && !ins.valid && (ev == '0);
  endsequence

  sequence s_op_here(pfr_pkg::pfr_op_t o);
    ins.valid && ins.dest_flags && (ins.op == o);
  endsequence

  sequence s_op_else(pfr_pkg::pfr_op_t o);
    ins.valid && !ins.dest_flags && (ins.op == o);
  endsequence

  sequence s_no_event;
    ev == '0;
  endsequence

  chk_add_flags_win: assert property ( // RQ1
    s_op_here(pfr_pkg::PFR_OP_ADD) |=>
      flags_r[ZR] == (($past(flags_r) + $past(ins.opb)) == 8'h00) &&
      flags_r[CY] == (({1'b0, $past(flags_r)} + {1'b0, $past(ins.opb)}) > 9'h0FF)
  ) else $error("computed flags lost on write");

  chk_wd_pd_locked: assert property ( // RQ2
    s_plain_flag_wr |=>
      $stable(flags_r[WD]) && $stable(flags_r[PD])
  ) else $error("expiry or power-down flag written");

  chk_clear_file_here: assert property ( // RQ3
    s_op_here(pfr_pkg::PFR_OP_CLEAR_FILE) ##0 s_no_event |=>
      flags_r[7:5] == 3'b000 && flags_r[ZR] &&
      flags_r[4:3] == $past(flags_r[4:3]) &&
      flags_r[1:0] == $past(flags_r[1:0])
  ) else $error("clear-file on flags wrong");

  chk_bank_address: assert property ( // RQ6
    1'b1 |=> mem_addr_r == {$past(flags_r[BK]), $past(dir_addr)}
  ) else $error("bank address mismatch");

  chk_sub_nibble: assert property ( // RQ7
    s_op_else(pfr_pkg::PFR_OP_SUB) |=>
      flags_r[NB] == ($past(ins.opa[3:0]) >= $past(ins.opb[3:0]))
  ) else $error("nibble borrow polarity wrong");

  chk_sub_carry: assert property ( // RQ8
    s_op_else(pfr_pkg::PFR_OP_SUB) |=>
      flags_r[CY] == ($past(ins.opa) >= $past(ins.opb))
  ) else $error("borrow polarity wrong");

  chk_rotate_left_carry: assert property ( // RQ9
    s_op_else(pfr_pkg::PFR_OP_ROT_LEFT) |=> flags_r[CY] == $past(ins.opa[7])
  ) else $error("left rotate carry wrong");

  chk_rotate_right_carry: assert property ( // RQ9
    s_op_else(pfr_pkg::PFR_OP_ROT_RIGHT) |=> flags_r[CY] == $past(ins.opa[0])
  ) else $error("right rotate carry wrong");

  property p_option_rw;
    logic [7:0] v;
    (bus_wr && opt_hit, v = bus_wdata) ##1 (bus_rd && opt_hit) |=> bus_rdata_r == v;
  endproperty

  chk_option_readback: assert property (p_option_rw) // RQ10
    else $error("option readback wrong");

  // Watchdog and sleep events
  chk_expiry_clears: assert property ( // RQ12
    ev.expiry |=> !flags_r[WD]
  ) else $error("expiry flag not cleared");

  chk_wd_clear_flags: assert property ( // RQ12
    ev.wd_clear && !ev.expiry && !ev.sleep_entry |=> flags_r[WD] && flags_r[PD]
  ) else $error("watchdog clear flags wrong");

  chk_sleep_flags: assert property ( // RQ12
    ev.sleep_entry && !ev.expiry |=> flags_r[WD] && !flags_r[PD]
  ) else $error("sleep flags wrong");

  chk_zero_and: assert property ( // RQ13
    s_op_else(pfr_pkg::PFR_OP_AND) |=>
      flags_r[ZR] == ($past(ins.opa & ins.opb) == 8'h00)
  ) else $error("zero flag wrong");

  chk_read_one_cycle: assert property (
    !bus_rd |=> bus_rdata_r == 8'h00
  ) else $error("read data outside its cycle");

  // Any move outside an event means the write guard leaks
  chk_flags_idle: assert property ( // RQ2
    s_no_event |=> $stable(flags_r[WD]) && $stable(flags_r[PD])
  ) else $error("expiry or power-down flag moved without event");

  // Bus writes to the flags act like a move from W
  chk_flag_wr_value: assert property (
    s_plain_flag_wr |=>
      flags_r[7:5] == $past(bus_wdata[7:5]) && flags_r[2:0] == $past(bus_wdata[2:0])
  ) else $error("flag write lost");

  chk_option_hold: assert property ( // RQ10
    !(bus_wr && opt_hit) |=> $stable(option_r)
  ) else $error("option changed without write");

  chk_read_flags: assert property (
    bus_rd && flags_hit |=> bus_rdata_r == $past(flags_r)
  ) else $error("flag read data wrong");

  chk_unmapped_read: assert property (
    bus_rd && !flags_hit && !opt_hit |=> bus_rdata_r == 8'h00
  ) else $error("unmapped read not zero");

  chk_result_pulse: assert property (
    1'b1 |=> result_valid_r == $past(ins.valid)
  ) else $error("result valid pulse wrong");

  chk_move_w_here: assert property ( // RQ1
    s_op_here(pfr_pkg::PFR_OP_MOVE_W) ##0 s_no_event |=>
      flags_r[7:5] == $past(ins.opb[7:5]) && flags_r[2:0] == $past(ins.opb[2:0])
  ) else $error("move to flags wrong");

  // Expected carries built from the operands, not from the adder
  chk_add_carries: assert property ( // RQ13
    s_op_else(pfr_pkg::PFR_OP_ADD) |=>
      flags_r[NB] == (({1'b0, $past(ins.opa[3:0])} + {1'b0, $past(ins.opb[3:0])}) > 5'h0F) &&
      flags_r[CY] == (({1'b0, $past(ins.opa)} + {1'b0, $past(ins.opb)}) > 9'h0FF)
  ) else $error("add carries wrong");

endmodule

`default_nettype wire

// >>> tb/pfr_core_model.sv
// Core model: issues one operation or one event pulse at a time.
// Assumes the flag block samples ins and ev on rising mclk edges.
`timescale 1ns/1ps
`default_nettype none
module pfr_core_model (
  input wire logic mclk,
  output var pfr_pkg::pfr_instr_t ins,
  output var pfr_pkg::pfr_event_t ev
);
  initial begin
    ins = '0;
    ev = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Idle operands flip so a stale operand never looks valid
  task automatic issue(input pfr_pkg::pfr_instr_t i);
    @(posedge mclk);
    ins <= i;
    @(posedge mclk);
    ins <= ~i;
  endtask
  // Event pulses last exactly one cycle
  task automatic pulse(input pfr_pkg::pfr_event_t e);
    @(posedge mclk);
    ev <= e;
    @(posedge mclk);
    ev <= '0;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_cpu_status_flag_register.sv
// Bench for the processor flag register: bus, operation and event tests.
// Assumes the core model in pfr_core_model drives the instruction port.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_status_flag_register;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [6:0] dir_addr = 7'h00;
  logic [7:0] bus_rdata_r, mem_addr_r, result_r, flags_r, option_r, d;
  logic result_valid_r;
  pfr_pkg::pfr_instr_t ins;
  pfr_pkg::pfr_event_t ev;
  int failures = 0;
  int total_checks = 0;

  always #5 mclk = ~mclk;

  pfr_core_model u_core (.mclk(mclk), .ins(ins), .ev(ev));
  pfr_flags u_dut (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata_r(bus_rdata_r), .ins(ins), .ev(ev), .dir_addr(dir_addr),
    .mem_addr_r(mem_addr_r), .result_r(result_r),
    .result_valid_r(result_valid_r), .flags_r(flags_r), .option_r(option_r));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= w;
    @(posedge mclk);
    bus_wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    q = bus_rdata_r;
  endtask

  // Write then read back with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] w, output logic [7:0] q);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= w;
    @(posedge mclk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    q = bus_rdata_r;
  endtask

  task automatic op(input pfr_pkg::pfr_op_t o, input logic dst,
    input logic [7:0] a, input logic [7:0] b, input logic [7:0] r,
    input logic [7:0] f);
    u_core.issue({1'b1, o, dst, a, b, 3'h0});
    #1;
    chk("result", r, result_r);
    chk("flags", f, flags_r);
    chk("valid", 8'h01, {7'h00, result_valid_r});
  endtask

  task automatic evt(input pfr_pkg::pfr_event_t e, input logic [7:0] f);
    u_core.pulse(e);
    #1;
    chk("event flags", f, flags_r);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Whole run is under a hundred cycles; the limit leaves wide margin
  initial begin
    #20us;
    failures++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge mclk);
    chk("flags reset", 8'h18, flags_r);
    chk("option reset", 8'hFF, option_r);
    rst_n <= 1'b1;
    wr(8'h81, 8'h5A);
    rd(8'h81, d);
    chk("option", 8'h5A, d);
    wr_rd(8'h81, 8'hC3, d);
    chk("option b2b", 8'hC3, d);
    wr(8'h81, 8'h08);
    chk("assign", 8'h01, {7'h00, option_r[pfr_pkg::PFR_PRESCALER_ASSIGN_BIT]});
    rd(8'h44, d);
    chk("unmapped", 8'h00, d);
    wr(8'h03, 8'h00);
    chk("flags wr", 8'h18, flags_r);
    wr(8'h83, 8'h27);
    chk("flags alias", 8'h3F, flags_r);
    rd(8'h03, d);
    chk("flags rd", 8'h3F, d);
    $display("test registers done");
    @(posedge mclk);
    dir_addr <= 7'h15;
    @(posedge mclk);
    #1;
    chk("bank high", 8'h95, mem_addr_r);
    wr(8'h03, 8'h00);
    // Address follows the bank one cycle after the flag write lands
    @(posedge mclk);
    #1;
    chk("bank low", 8'h15, mem_addr_r);
    $display("test bank done");
    op(pfr_pkg::PFR_OP_SUB, 1'b0, 8'h05, 8'h03, 8'h02, 8'h1B);
    op(pfr_pkg::PFR_OP_SUB, 1'b0, 8'h03, 8'h05, 8'hFE, 8'h18);
    op(pfr_pkg::PFR_OP_AND, 1'b0, 8'hF0, 8'h0F, 8'h00, 8'h1C);
    op(pfr_pkg::PFR_OP_IOR, 1'b0, 8'h50, 8'h05, 8'h55, 8'h18);
    op(pfr_pkg::PFR_OP_XOR, 1'b0, 8'h55, 8'h55, 8'h00, 8'h1C);
    op(pfr_pkg::PFR_OP_INC, 1'b0, 8'hFF, 8'h00, 8'h00, 8'h1C);
    op(pfr_pkg::PFR_OP_NIBBLE_SWAP, 1'b0, 8'hA5, 8'h00, 8'h5A, 8'h1C);
    op(pfr_pkg::PFR_OP_ADD, 1'b0, 8'h80, 8'h80, 8'h00, 8'h1D);
    op(pfr_pkg::PFR_OP_ADD, 1'b0, 8'h0F, 8'h01, 8'h10, 8'h1A);
    op(pfr_pkg::PFR_OP_ROT_LEFT, 1'b0, 8'h81, 8'h00, 8'h02, 8'h1B);
    op(pfr_pkg::PFR_OP_ROT_RIGHT, 1'b0, 8'h02, 8'h00, 8'h81, 8'h1A);
    op(pfr_pkg::PFR_OP_ADD, 1'b1, 8'h1A, 8'hE6, 8'h00, 8'h1F);
    op(pfr_pkg::PFR_OP_MOVE_W, 1'b1, 8'h1F, 8'h21, 8'h21, 8'h39);
    op(pfr_pkg::PFR_OP_BIT_CLEAR, 1'b1, 8'h39, 8'h00, 8'h38, 8'h38);
    op(pfr_pkg::PFR_OP_BIT_SET, 1'b1, 8'h38, 8'h00, 8'h39, 8'h39);
    op(pfr_pkg::PFR_OP_CLEAR_FILE, 1'b1, 8'h39, 8'h00, 8'h00, 8'h1D);
    $display("test alu done");
    evt(3'b100, 8'h0D);
    evt(3'b010, 8'h1D);
    evt(3'b001, 8'h15);
    evt(3'b101, 8'h05);
    evt(3'b010, 8'h1D);
    $display("test events done");
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    #1;
    chk("flags rereset", 8'h18, flags_r);
    chk("option rereset", 8'hFF, option_r);
    rst_n <= 1'b1;
    rd(8'h81, d);
    chk("option after reset", 8'hFF, d);
    $display("test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
